// ==== rtl/icm_pkg.sv ====
package icm_pkg;
   // register byte addresses
   localparam logic [11:0] UPPER_CHANNEL_MASK_SET_OFFS = 12'h070;
   localparam logic [11:0] UPPER_CHANNEL_MASK_CLEAR_OFFS = 12'h074;
   localparam logic [11:0] RX_STATUS_OFFS = 12'h0f0;
   // mask reset value: undefined in hardware, zero here so nothing is received before setup
   localparam logic [31:0] MASK_RESET = 32'h0000_0000;
   localparam int MASK_BITS = 32;
   localparam logic [5:0] CHANNEL_BASE = 6'h20;
   localparam logic [5:0] CHANNEL_TOP = 6'h3f;
   localparam logic [31:0] RX_STATUS_RESET = 32'h0000_0000;
   typedef enum logic [1:0] {
      ICM_IDLE = 2'b00,
      ICM_ACCESS = 2'b01
   } icm_phase_type;
endpackage

// ==== rtl/icm_apb_decode.sv ====
`timescale 1ns/100ps
module icm_apb_decode (
   input wire logic [11:0] paddr,
   output logic hit_set,
   output logic hit_clear,
   output logic hit_status,
   output logic slverr
);
   always_comb begin
      hit_set = 1'b0;
      hit_clear = 1'b0;
      hit_status = 1'b0;
      slverr = 1'b0;
      if (paddr == icm_pkg::UPPER_CHANNEL_MASK_SET_OFFS) begin
         hit_set = 1'b1;
      end else if (paddr == icm_pkg::UPPER_CHANNEL_MASK_CLEAR_OFFS) begin
         hit_clear = 1'b1;
      end else if (paddr == icm_pkg::RX_STATUS_OFFS) begin
         hit_status = 1'b1;
      end else begin
         slverr = 1'b1;
      end
   end
endmodule

// ==== rtl/icm_chan_filter.sv ====
`timescale 1ns/100ps
module icm_chan_filter #(
   parameter int MASK_BITS = 32
) (
   input wire logic [MASK_BITS-1:0] mask,
   input wire logic [5:0] channel,
   output logic accept
);
   logic upper;
   logic [4:0] idx;
   always_comb begin
      // the lower 32 channels belong to another mask, so they never pass here
      upper = channel[5];
      idx = channel[4:0];
      accept = upper & mask[idx];
   end
endmodule

// ==== rtl/icm_upper_mask.sv ====
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
//Contract
//- set at 70h, clear at 74h, ones act
//- both addresses read mask, reads change nothing
//- 32 bits, bit n enables channel n+32
//- top bit set accepts channel 63
//- bottom bit set accepts channel 32
module icm_upper_mask #(
   parameter int MASK_BITS = icm_pkg::MASK_BITS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pkt_valid,
   input wire logic [5:0] pkt_channel,
   output logic pkt_accept,
   output logic pkt_ignore,
   output logic [MASK_BITS-1:0] chan_mask,
   output logic rx_enable_chan_top,
   output logic rx_enable_chan_base_upper
);
   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      icm_pkg::icm_phase_type phase;
      logic [MASK_BITS-1:0] mask;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
      logic accept;
      logic ignore;
      logic [15:0] accept_cnt;
      logic [15:0] ignore_cnt;
   } icm_state_type;

   icm_state_type st_q;
   icm_state_type st_d;
   logic hit_set;
   logic hit_clear;
   logic hit_status;
   logic dec_err;
   logic filt_accept;
   logic [31:0] bmask;
   logic [31:0] wbits;

   icm_apb_decode u_dec (
      .paddr(paddr),
      .hit_set(hit_set),
      .hit_clear(hit_clear),
      .hit_status(hit_status),
      .slverr(dec_err)
   );

   icm_chan_filter #(.MASK_BITS(MASK_BITS)) u_filt (
      .mask(st_q.mask),
      .channel(pkt_channel),
      .accept(filt_accept)
   );

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_d = st_q;
      st_d.ready = 1'b0;
      st_d.slverr = 1'b0;
      bmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
      wbits = pwdata & bmask;
      // one wait state: setup, then access answered one cycle later
      case (st_q.phase)
         icm_pkg::ICM_IDLE: begin
            if (psel && penable) begin
               st_d.phase = icm_pkg::ICM_ACCESS;
               st_d.ready = 1'b1;
               st_d.slverr = dec_err;
               if (pwrite) begin
                  if (hit_set) begin
                     st_d.mask = st_q.mask | wbits[MASK_BITS-1:0];
                  end else if (hit_clear) begin
                     st_d.mask = st_q.mask & ~wbits[MASK_BITS-1:0];
                  end
                  st_d.rdata = 32'h0000_0000;
               end else if (hit_set || hit_clear) begin
                  st_d.rdata = 32'(st_q.mask);
               end else if (hit_status) begin
                  st_d.rdata = {st_q.accept_cnt, st_q.ignore_cnt};
               end else begin
                  st_d.rdata = 32'h0000_0000;
               end
            end
         end
         icm_pkg::ICM_ACCESS: begin
            st_d.phase = icm_pkg::ICM_IDLE;
         end
         default: begin
            st_d.phase = icm_pkg::ICM_IDLE;
         end
      endcase
      // packet filter: accept when mask bit for channel-32 is set
      st_d.accept = pkt_valid & filt_accept;
      st_d.ignore = pkt_valid & ~filt_accept;
      if (pkt_valid && filt_accept) begin
         st_d.accept_cnt = st_q.accept_cnt + 16'h0001;
      end
      if (pkt_valid && !filt_accept) begin
         st_d.ignore_cnt = st_q.ignore_cnt + 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q.phase <= icm_pkg::ICM_IDLE;
         st_q.mask <= icm_pkg::MASK_RESET[MASK_BITS-1:0];
         st_q.rdata <= 32'h0000_0000;
         st_q.ready <= 1'b0;
         st_q.slverr <= 1'b0;
         st_q.accept <= 1'b0;
         st_q.ignore <= 1'b0;
         st_q.accept_cnt <= 16'h0000;
         st_q.ignore_cnt <= 16'h0000;
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign prdata = st_q.rdata;
   assign pready = st_q.ready;
   assign pslverr = st_q.slverr;
   assign pkt_accept = st_q.accept;
   assign pkt_ignore = st_q.ignore;
   assign chan_mask = st_q.mask;
   assign rx_enable_chan_top = st_q.mask[MASK_BITS-1];
   assign rx_enable_chan_base_upper = st_q.mask[0];

   ////////////////////////////////////////////////////////////////////////
   // bus side: every access is answered after exactly one wait state
   set_write_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && !pready && paddr == icm_pkg::UPPER_CHANNEL_MASK_SET_OFFS && pstrb == 4'hf)
      |=> chan_mask == ($past(chan_mask) | $past(pwdata)))
      else $error("set write did not or ones into mask");

   clear_write_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && !pready && paddr == icm_pkg::UPPER_CHANNEL_MASK_CLEAR_OFFS && pstrb == 4'hf)
      |=> chan_mask == ($past(chan_mask) & ~$past(pwdata)))
      else $error("clear write did not remove ones from mask");

   read_back_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && !pwrite && !pready
       && (paddr == icm_pkg::UPPER_CHANNEL_MASK_SET_OFFS || paddr == icm_pkg::UPPER_CHANNEL_MASK_CLEAR_OFFS))
      |=> pready && prdata == $past(chan_mask) && $stable(chan_mask))
      else $error("mask read returned wrong data or changed mask");

   other_stable_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !(psel && penable && pwrite)
      |=> $stable(chan_mask))
      else $error("mask changed without a write");

   zero_keep_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && !pready)
      |=> ((chan_mask ^ $past(chan_mask)) & ~$past(pwdata[MASK_BITS-1:0])) == '0)
      else $error("zero write bit changed the mask");

   set_no_clear_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && !pready && paddr == icm_pkg::UPPER_CHANNEL_MASK_SET_OFFS)
      |=> ($past(chan_mask) & ~chan_mask) == '0)
      else $error("set write cleared a mask bit");

   clear_no_set_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && !pready && paddr == icm_pkg::UPPER_CHANNEL_MASK_CLEAR_OFFS)
      |=> (chan_mask & ~$past(chan_mask)) == '0)
      else $error("clear write set a mask bit");

   strobe_keep_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && !pready && pstrb == 4'h0)
      |=> $stable(chan_mask))
      else $error("write with no byte lanes changed the mask");

   read_keep_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && !pwrite && !pready)
      |=> $stable(chan_mask))
      else $error("read changed the mask");

   unmapped_keep_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready && paddr != icm_pkg::UPPER_CHANNEL_MASK_SET_OFFS
       && paddr != icm_pkg::UPPER_CHANNEL_MASK_CLEAR_OFFS)
      |=> $stable(chan_mask))
      else $error("access to another address changed the mask");

   access_answer_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready)
      |=> pready)
      else $error("access not answered after one wait state");

   ready_pulse_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      pready
      |=> !pready)
      else $error("ready stood longer than one cycle");

   ready_cause_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !(psel && penable)
      |=> !pready)
      else $error("ready without an access");

   err_with_ready_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      pslverr
      |-> pready)
      else $error("error shown without ready");

   unmapped_err_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready && paddr != icm_pkg::UPPER_CHANNEL_MASK_SET_OFFS
       && paddr != icm_pkg::UPPER_CHANNEL_MASK_CLEAR_OFFS && paddr != icm_pkg::RX_STATUS_OFFS)
      |=> pready && pslverr)
      else $error("unmapped access not flagged");

   mapped_ok_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready
       && (paddr == icm_pkg::UPPER_CHANNEL_MASK_SET_OFFS || paddr == icm_pkg::UPPER_CHANNEL_MASK_CLEAR_OFFS))
      |=> pready && !pslverr)
      else $error("mask access flagged as error");

   unmapped_rdata_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && !pwrite && !pready && paddr != icm_pkg::UPPER_CHANNEL_MASK_SET_OFFS
       && paddr != icm_pkg::UPPER_CHANNEL_MASK_CLEAR_OFFS && paddr != icm_pkg::RX_STATUS_OFFS)
      |=> prdata == 32'h0)
      else $error("unmapped read returned data");

   ////////////////////////////////////////////////////////////////////////
   // packet side: the verdict stands one cycle after the header
   top_chan_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pkt_valid && pkt_channel == icm_pkg::CHANNEL_TOP && rx_enable_chan_top)
      |=> pkt_accept)
      else $error("channel 63 refused while enabled");

   base_chan_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pkt_valid && pkt_channel == icm_pkg::CHANNEL_BASE && rx_enable_chan_base_upper)
      |=> pkt_accept)
      else $error("channel 32 refused while enabled");

   cleared_ignore_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pkt_valid && pkt_channel[5] && !chan_mask[pkt_channel[4:0]])
      |=> pkt_ignore && !pkt_accept)
      else $error("packet on disabled channel accepted");

   chan_map_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pkt_valid && pkt_channel[5])
      |=> pkt_accept == $past(chan_mask[pkt_channel[4:0]]))
      else $error("channel n+32 not governed by bit n");

   lower_chan_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pkt_valid && !pkt_channel[5])
      |=> pkt_ignore && !pkt_accept)
      else $error("lower channel packet accepted");

   top_chan_off_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pkt_valid && pkt_channel == icm_pkg::CHANNEL_TOP && !rx_enable_chan_top)
      |=> pkt_ignore && !pkt_accept)
      else $error("channel 63 accepted while disabled");

   base_chan_off_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pkt_valid && pkt_channel == icm_pkg::CHANNEL_BASE && !rx_enable_chan_base_upper)
      |=> pkt_ignore && !pkt_accept)
      else $error("channel 32 accepted while disabled");

   pkt_one_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      pkt_valid
      |=> pkt_accept != pkt_ignore)
      else $error("packet got no verdict or two");

   pkt_quiet_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !pkt_valid
      |=> !pkt_accept && !pkt_ignore)
      else $error("verdict without a packet");
endmodule

// ==== tb/icm_upper_mask_tb.sv ====
`timescale 1ns/100ps
module icm_upper_mask_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic [31:0] prdata;
   logic pready, pslverr, pkt_accept, pkt_ignore, en_top, en_base;
   logic pkt_valid = 1'b0;
   logic [5:0] pkt_channel = 6'h00;
   logic [31:0] chan_mask, m, rd, r, b, seed = 32'he25401a1;
   logic [3:0] s;
   logic er;
   int n_errors = 0;
   int cmp_count = 0;
   int n_acc = 0;
   int n_ign = 0;
   always #2 pclk = ~pclk;
   icm_upper_mask #(.MASK_BITS(icm_pkg::MASK_BITS)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pkt_valid(pkt_valid), .pkt_channel(pkt_channel),
      .pkt_accept(pkt_accept), .pkt_ignore(pkt_ignore), .chan_mask(chan_mask),
      .rx_enable_chan_top(en_top), .rx_enable_chan_base_upper(en_base));
   ////////////////////////////////////////////////////////////////////////////////
   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // leading edge wait keeps release and next setup out of one time step
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] st,
      output logic [31:0] q, output logic e);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= st;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) chk(32'h0, 32'h1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
      pstrb <= 4'h0;
   endtask
   task check_status();
      apb(1'b0, icm_pkg::RX_STATUS_OFFS, xs(), 4'h0, rd, er);
      chk(rd, {16'(n_acc), 16'(n_ign)});
      chk({31'h0, er}, 32'h0);
   endtask
   task check_mask();
      apb(1'b0, icm_pkg::UPPER_CHANNEL_MASK_SET_OFFS, xs(), 4'h0, rd, er);
      chk(rd, m);
      apb(1'b0, icm_pkg::UPPER_CHANNEL_MASK_CLEAR_OFFS, xs(), 4'h0, rd, er);
      chk(rd, m);
      chk(chan_mask, m);
      chk({31'h0, en_top}, {31'h0, m[31]});
      chk({31'h0, en_base}, {31'h0, m[0]});
   endtask
   task pkt(input logic [5:0] c);
      logic acc;
      @(posedge pclk);
      pkt_valid <= 1'b1;
      pkt_channel <= c;
      @(posedge pclk);
      pkt_valid <= 1'b0;
      pkt_channel <= ~c;
      @(posedge pclk);
      acc = c[5] & m[c[4:0]];
      if (acc)
         n_acc++;
      else
         n_ign++;
      chk({31'h0, pkt_accept}, {31'h0, acc});
      chk({31'h0, pkt_ignore}, {31'h0, ~acc});
   endtask
   task results();
      $display("errors %0d comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #40000;
      n_errors++;
      $display("BAD %0t watchdog expired", $time);
      results();
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      m = icm_pkg::MASK_RESET;
      chk(chan_mask, m);
      for (int i = 0; i < 26; i++) begin
         r = (i == 0) ? 32'hffffffff : (i == 1) ? 32'h80000001 : xs();
         s = (i > 3 && xs() < 32'h40000000) ? 4'(xs()) : 4'hf;
         b = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
         if ((i == 1) || (i > 1 && xs() < 32'h80000000)) begin
            m = m | (r & b);
            apb(1'b1, icm_pkg::UPPER_CHANNEL_MASK_SET_OFFS, r, s, rd, er);
         end else begin
            m = m & ~(r & b);
            apb(1'b1, icm_pkg::UPPER_CHANNEL_MASK_CLEAR_OFFS, r, s, rd, er);
         end
         chk({31'h0, er}, 32'h0);
         check_mask();
         if (i == 1 || i % 8 == 7) begin
            for (int c = 0; c < 64; c++) pkt(6'(c));
         end
      end
      // unmapped neighbour must not touch the mask
      apb(1'b1, 12'h078, 32'hffffffff, 4'hf, rd, er);
      chk({31'h0, er}, 32'h1);
      check_mask();
      apb(1'b0, 12'h078, xs(), 4'h0, rd, er);
      chk(rd, 32'h0);
      chk({31'h0, er}, 32'h1);
      check_status();
      // mid-run reset: mask back to its reset value, counts restart
      @(posedge pclk);
      presetn <= 1'b0;
      m = icm_pkg::MASK_RESET;
      n_acc = 0;
      n_ign = 0;
      repeat (3) @(posedge pclk);
      chk(chan_mask, m);
      presetn <= 1'b1;
      check_mask();
      check_status();
      pkt(icm_pkg::CHANNEL_TOP);
      pkt(icm_pkg::CHANNEL_BASE);
      apb(1'b1, icm_pkg::UPPER_CHANNEL_MASK_SET_OFFS, 32'h80000001, 4'hf, rd, er);
      m = m | 32'h80000001;
      chk({31'h0, er}, 32'h0);
      pkt(icm_pkg::CHANNEL_TOP);
      pkt(icm_pkg::CHANNEL_BASE);
      check_mask();
      check_status();
      results();
   end
endmodule
